/* hw/mcs_map.svh */
// Offsets, field positions, reset values and timing counts of the controller.
`ifndef MCS_MAP_SVH
`define MCS_MAP_SVH

// Controller register offsets (byte addresses on the software port).
`define MCS_OFS_CTRL 8'h00
`define MCS_OFS_STATUS 8'h04
`define MCS_OFS_ALIGN 8'h08
`define MCS_OFS_FMT 8'h0C
`define MCS_OFS_MAIN 8'h10
`define MCS_OFS_PLL 8'h14
`define MCS_OFS_FUSE 8'h18
`define MCS_OFS_ALARM 8'h1C

// Control register fields.
`define MCS_CTRL_START 0
`define MCS_CTRL_PLL 1
`define MCS_CTRL_RETRY 2

// Status register fields.
`define MCS_STAT_BUSY 8
`define MCS_STAT_RUN 9
`define MCS_STAT_FAIL 10
`define MCS_STAT_ALARM 11

// Device register addresses on the serial interface.
`define MCS_DEV_MAIN 7'h00
`define MCS_DEV_ALARM 7'h05
`define MCS_DEV_PLL 7'h18
`define MCS_DEV_FUSE 7'h1B
`define MCS_DEV_FMT 7'h1F
`define MCS_DEV_ALIGN 7'h20

// Device register field positions.
`define MCS_BIT_CLKDIV_ENA 2
`define MCS_BIT_NDIV_SYNC 11
`define MCS_BIT_FUSE_SLEEP 11
`define MCS_BIT_CLKDIV_SEL 0
`define MCS_CLKDIV_SEL_OUTPUT_STROBE 1'h1

// Reset values of the device images held by the controller.
`define MCS_RST_ALIGN 16'h0000
`define MCS_RST_FMT 16'h0000
`define MCS_RST_MAIN 16'h0000
`define MCS_RST_PLL 16'h0000
`define MCS_RST_FUSE 16'h0000

// Timing.
`define MCS_CLK_NS 8
`define MCS_RESET_NS 25
`define MCS_RST_CYC ((`MCS_RESET_NS + `MCS_CLK_NS - 1) / `MCS_CLK_NS)
`define MCS_SYNC_CYC 16
`define MCS_SETTLE_CYC 64
`define MCS_SIF_HALF 8

`endif

/* hw/mcs_pkg.sv */
// Types shared by the sync controller and its serial master.
package mcs_pkg;

  typedef logic [15:0] mcs_word_t;
  typedef logic [7:0] mcs_addr_t;
  typedef logic [6:0] mcs_dev_addr_t;

  typedef enum logic [4:0]
  {
    S_IDLE = 5'h00,
    S_RST = 5'h01,
    S_RWAIT = 5'h03,
    S_FUSE = 5'h02,
    S_FMT = 5'h06,
    S_ALIGN = 5'h07,
    S_MAIN = 5'h05,
    S_PLLON = 5'h04,
    S_NSYNC = 5'h0C,
    S_PLLOFF = 5'h0D,
    S_SYNC = 5'h0F,
    S_SETTLE = 5'h0E,
    S_RDALM = 5'h0A,
    S_CHECK = 5'h0B,
    S_CLKOFF = 5'h09,
    S_RUN = 5'h08,
    S_FAIL = 5'h18
  } mcs_state_e;

endpackage

/* hw/mcs_sif_master.sv */
// Serial interface master: 24-bit frames, sclk from a divider, shared sdio.
`timescale 1ns/1ns
`include "mcs_map.svh"

module mcs_sif_master #(
  parameter int HALF = `MCS_SIF_HALF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command side
  input wire logic start,
  input wire logic rnw,
  input wire mcs_pkg::mcs_dev_addr_t addr,
  input wire mcs_pkg::mcs_word_t wdata,
  output logic busy,
  output logic done,
  output mcs_pkg::mcs_word_t rdata,
  // Serial pins
  output logic sclk,
  output logic sdenb_n,
  output logic sdio_out,
  output logic sdio_oe_n,
  input wire logic sdio_in
);
  import mcs_pkg::*;

  logic active_reg;
  logic [7:0] div_reg;
  logic [4:0] bit_reg;
  logic [23:0] shift_reg;
  logic rnw_reg;
  logic sclk_reg;
  logic done_reg;
  logic [2:0] sdio_sync;
  logic sdio_q;
  mcs_word_t rdata_reg;
  logic tick;

  assign tick = div_reg == 8'(HALF - 1);

  always_ff @(posedge clk)
  begin
    if (rst || !active_reg || tick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  // Data changes on the falling edge so the device sees it stable at rise.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_reg <= 1'b0;
      sclk_reg <= 1'b0;
      bit_reg <= 5'h00;
      shift_reg <= 24'h000000;
      rnw_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (!active_reg && start)
      begin
        active_reg <= 1'b1;
        shift_reg <= {rnw, addr, wdata};
        rnw_reg <= rnw;
        bit_reg <= 5'h00;
        sclk_reg <= 1'b0;
      end
      else if (active_reg && tick)
      begin
        if (!sclk_reg)
          sclk_reg <= 1'b1;
        else
        begin
          sclk_reg <= 1'b0;
          if (bit_reg == 5'h17)
          begin
            active_reg <= 1'b0;
            done_reg <= 1'b1;
          end
          else
          begin
            bit_reg <= bit_reg + 5'h01;
            shift_reg <= {shift_reg[22:0], 1'b0};
          end
        end
      end
    end
  end

  // The synchroniser costs four cycles, well inside a half period.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sdio_sync <= 3'h0;
      sdio_q <= 1'b0;
    end
    else
    begin
      sdio_sync <= {sdio_sync[1:0], sdio_in};
      if (sdio_sync[1] == sdio_sync[2])
        sdio_q <= sdio_sync[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_reg <= 16'h0000;
    else if (active_reg && tick && sclk_reg && rnw_reg && bit_reg >= 5'h08)
      rdata_reg <= {rdata_reg[14:0], sdio_q};
  end

  assign busy = active_reg;
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign sclk = sclk_reg;
  assign sdenb_n = !active_reg;
  assign sdio_out = shift_reg[23];
  assign sdio_oe_n = !(active_reg && (!rnw_reg || bit_reg < 5'h08));

  property p_frame_ends;
    @(posedge clk) disable iff (rst)
    $fell(sdenb_n) |-> !sdenb_n [*8] ##[1:1000] sdenb_n;
  endproperty
  a_frame_ends: assert property (p_frame_ends)
    else $error("serial frame did not end in time");

  property p_read_releases;
    @(posedge clk) disable iff (rst)
    (active_reg && rnw_reg && bit_reg >= 5'h08) |-> sdio_oe_n;
  endproperty
  a_read_releases: assert property (p_read_releases)
    else $error("sdio driven during read data phase");

endmodule

/* hw/mcs_sync_ctrl.sv */
// Start-up and multi-device sync sequencer that drives the converter's pins.
`timescale 1ns/1ns
`include "mcs_map.svh"

// Behaviour
// - With PLL bypassed, use dual sync mode and strobe as divider source.
// - After alignment, confirm no FIFO alarm in status or on alarm pin.
// - When alignment is complete, write zero to divider alignment enable.
// - One sync edge suffices; clear prescaler alignment enable afterwards.
// - PLL order: divider reset, disable it, align, check alarms, disable.
// - Hold transmit gate low; reset pin low at least 25 ns first.
// - After programming, set fuse sleep bit 11 of its register; the code sets it in the first write, before the other registers.
// - Present all link inputs together, then supply the alignment pulses.
// - In single source mode issue one rising edge for all alignment.
// - Converter clock may come before or after register programming.
// - On clock loss or FIFO alarm drop gate and redo alignment; the code reacts to the alarm pin in run, and at check with the retry bit set to pin or alarm word.
// - Transmission starts only when the gate pin or software bit is set.
module mcs_sync_ctrl #(
  parameter int SYNC_CYC = `MCS_SYNC_CYC,
  parameter int SETTLE_CYC = `MCS_SETTLE_CYC,
  parameter int SIF_HALF = `MCS_SIF_HALF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Software register port
  input wire mcs_pkg::mcs_addr_t reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Converter control pins
  output logic active_low_reset_pin_n,
  output logic txenable,
  output logic sync_out,
  output logic lvds_en,
  input wire logic alarm_in,
  // Serial interface pins
  output logic sclk,
  output logic sdenb_n,
  output logic sdio_out,
  output logic sdio_oe_n,
  input wire logic sdio_in
);
  import mcs_pkg::*;

  localparam int RST_CYC = `MCS_RST_CYC;

  mcs_state_e state_reg;
  mcs_state_e state_next;
  logic [15:0] cnt_reg;
  logic pll_mode_reg;
  logic retry_reg;
  logic start_reg;
  mcs_word_t align_val_reg;
  mcs_word_t fmt_val_reg;
  mcs_word_t main_val_reg;
  mcs_word_t pll_val_reg;
  mcs_word_t fuse_val_reg;
  mcs_word_t alarm_word_reg;
  logic [2:0] alarm_sync;
  logic alarm_q;
  logic issued_reg;
  logic active_low_reset_pin_reg;
  logic tx_reg;
  logic sync_reg;
  logic lvds_reg;
  logic fail_reg;
  logic [31:0] rdata_reg;
  logic sif_state;
  logic sif_start;
  logic sif_rnw;
  mcs_dev_addr_t sif_addr;
  mcs_word_t sif_wdata;
  logic sif_busy;
  logic sif_done;
  mcs_word_t sif_rdata;
  logic pulse_state;
  logic alarm_bad;

  // Software register writes.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_reg <= 1'b0;
      pll_mode_reg <= 1'b0;
      retry_reg <= 1'b0;
      align_val_reg <= `MCS_RST_ALIGN;
      fmt_val_reg <= `MCS_RST_FMT;
      main_val_reg <= `MCS_RST_MAIN;
      pll_val_reg <= `MCS_RST_PLL;
      fuse_val_reg <= `MCS_RST_FUSE;
    end
    else
    begin
      start_reg <= 1'b0;
      if (reg_wr)
      begin
        case (reg_addr)
          `MCS_OFS_CTRL:
          begin
            start_reg <= reg_wdata[`MCS_CTRL_START];
            pll_mode_reg <= reg_wdata[`MCS_CTRL_PLL];
            retry_reg <= reg_wdata[`MCS_CTRL_RETRY];
          end
          `MCS_OFS_ALIGN: align_val_reg <= reg_wdata[15:0];
          `MCS_OFS_FMT: fmt_val_reg <= reg_wdata[15:0];
          `MCS_OFS_MAIN: main_val_reg <= reg_wdata[15:0];
          `MCS_OFS_PLL: pll_val_reg <= reg_wdata[15:0];
          `MCS_OFS_FUSE: fuse_val_reg <= reg_wdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Software register reads; unmapped offsets read zero.
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_reg <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `MCS_OFS_CTRL:
          rdata_reg <= {29'h00000000, retry_reg, pll_mode_reg, 1'b0};
        `MCS_OFS_STATUS:
          rdata_reg <= {20'h00000, alarm_q, fail_reg, state_reg == S_RUN,
                        state_reg != S_IDLE, 3'h0, state_reg};
        `MCS_OFS_ALIGN: rdata_reg <= {16'h0000, align_val_reg};
        `MCS_OFS_FMT: rdata_reg <= {16'h0000, fmt_val_reg};
        `MCS_OFS_MAIN: rdata_reg <= {16'h0000, main_val_reg};
        `MCS_OFS_PLL: rdata_reg <= {16'h0000, pll_val_reg};
        `MCS_OFS_FUSE: rdata_reg <= {16'h0000, fuse_val_reg};
        `MCS_OFS_ALARM: rdata_reg <= {16'h0000, alarm_word_reg};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;

  // The alarm pin is asynchronous: a change counts once stages 2 and 3 agree.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alarm_sync <= 3'h0;
      alarm_q <= 1'b0;
    end
    else
    begin
      alarm_sync <= {alarm_sync[1:0], alarm_in};
      if (alarm_sync[1] == alarm_sync[2])
        alarm_q <= alarm_sync[2];
    end
  end

  assign alarm_bad = alarm_q || (alarm_word_reg != 16'h0000);
  assign pulse_state = state_reg == S_NSYNC || state_reg == S_SYNC;

  // Sequencer.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (start_reg)
          state_next = S_RST;
      // The converter clock need not run yet, so nothing waits for it.
      S_RST:
        if (cnt_reg == 16'(RST_CYC - 1))
          state_next = S_RWAIT;
      S_RWAIT:
        if (cnt_reg == 16'(RST_CYC - 1))
          state_next = S_FUSE;
      S_FUSE:
        if (sif_done)
          state_next = S_FMT;
      S_FMT:
        if (sif_done)
          state_next = S_ALIGN;
      S_ALIGN:
        if (sif_done)
          state_next = S_MAIN;
      S_MAIN:
        if (sif_done)
          state_next = pll_mode_reg ? S_PLLON : S_SYNC;
      S_PLLON:
        if (sif_done)
          state_next = S_NSYNC;
      S_NSYNC:
        if (cnt_reg == 16'(2 * SYNC_CYC - 1))
          state_next = S_PLLOFF;
      S_PLLOFF:
        if (sif_done)
          state_next = S_SYNC;
      S_SYNC:
        if (cnt_reg == 16'(2 * SYNC_CYC - 1))
          state_next = S_SETTLE;
      S_SETTLE:
        if (cnt_reg == 16'(SETTLE_CYC - 1))
          state_next = S_RDALM;
      S_RDALM:
        if (sif_done)
          state_next = S_CHECK;
      S_CHECK:
        if (alarm_bad)
          state_next = retry_reg ? S_FMT : S_FAIL;
        else
          state_next = S_CLKOFF;
      S_CLKOFF:
        if (sif_done)
          state_next = S_RUN;
      S_RUN:
        if (alarm_q)
          state_next = S_FMT;
      S_FAIL:
        if (start_reg)
          state_next = S_RST;
        else if (retry_reg)
          state_next = S_FMT;
      default:
        state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_next != state_reg)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      fail_reg <= 1'b0;
    else if (state_reg == S_CHECK)
      fail_reg <= alarm_bad;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      alarm_word_reg <= 16'h0000;
    else if (state_reg == S_RDALM && sif_done)
      alarm_word_reg <= sif_rdata;
  end

  // Reset and gate pins follow the next state so they line up with the state itself; sync follows the current state and lags it a cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_low_reset_pin_reg <= 1'b1;
      tx_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      active_low_reset_pin_reg <= state_next != S_RST;
      tx_reg <= state_next == S_RUN;
      // One rising edge per pulse state; a lone edge is all the device needs.
      sync_reg <= pulse_state && cnt_reg < 16'(SYNC_CYC);
    end
  end

  // Data, data clock and frame are released together before any sync pulse.
  always_ff @(posedge clk)
  begin
    if (rst)
      lvds_reg <= 1'b0;
    else if (state_reg == S_MAIN && sif_done)
      lvds_reg <= 1'b1;
    else if (state_next inside {S_RST, S_FMT, S_IDLE})
      lvds_reg <= 1'b0;
  end

  assign active_low_reset_pin_n = active_low_reset_pin_reg;
  assign txenable = tx_reg;
  assign sync_out = sync_reg;
  assign lvds_en = lvds_reg;

  // Serial command for the current step.
  always_comb
  begin
    sif_state = 1'b1;
    sif_rnw = 1'b0;
    sif_addr = `MCS_DEV_MAIN;
    sif_wdata = main_val_reg;
    case (state_reg)
      S_FUSE:
      begin
        sif_addr = `MCS_DEV_FUSE;
        sif_wdata = fuse_val_reg;
        sif_wdata[`MCS_BIT_FUSE_SLEEP] = 1'b1;
      end
      S_FMT:
      begin
        sif_addr = `MCS_DEV_FMT;
        sif_wdata = fmt_val_reg;
      end
      S_ALIGN:
      begin
        sif_addr = `MCS_DEV_ALIGN;
        sif_wdata = align_val_reg;
        if (!pll_mode_reg)
          sif_wdata[`MCS_BIT_CLKDIV_SEL] = `MCS_CLKDIV_SEL_OUTPUT_STROBE;
      end
      S_MAIN:
        sif_wdata[`MCS_BIT_CLKDIV_ENA] = 1'b1;
      S_PLLON:
      begin
        sif_addr = `MCS_DEV_PLL;
        sif_wdata = pll_val_reg;
        sif_wdata[`MCS_BIT_NDIV_SYNC] = 1'b1;
      end
      S_PLLOFF:
      begin
        sif_addr = `MCS_DEV_PLL;
        sif_wdata = pll_val_reg;
        sif_wdata[`MCS_BIT_NDIV_SYNC] = 1'b0;
      end
      S_CLKOFF:
        sif_wdata[`MCS_BIT_CLKDIV_ENA] = 1'b0;
      S_RDALM:
      begin
        sif_addr = `MCS_DEV_ALARM;
        sif_rnw = 1'b1;
      end
      default:
        sif_state = 1'b0;
    endcase
  end

  // One frame per serial step; the flag stops a second launch.
  always_ff @(posedge clk)
  begin
    if (rst || sif_done)
      issued_reg <= 1'b0;
    else if (sif_start)
      issued_reg <= 1'b1;
  end

  assign sif_start = sif_state && !issued_reg && !sif_busy;

  mcs_sif_master #(
    .HALF(SIF_HALF)
  ) u_sif (
    .clk(clk),
    .rst(rst),
    .start(sif_start),
    .rnw(sif_rnw),
    .addr(sif_addr),
    .wdata(sif_wdata),
    .busy(sif_busy),
    .done(sif_done),
    .rdata(sif_rdata),
    .sclk(sclk),
    .sdenb_n(sdenb_n),
    .sdio_out(sdio_out),
    .sdio_oe_n(sdio_oe_n),
    .sdio_in(sdio_in)
  );

  property p_tx_only_run;
    @(posedge clk) disable iff (rst)
    txenable |-> state_reg == S_RUN;
  endproperty
  a_tx_only_run: assert property (p_tx_only_run)
    else $error("transmit gate high outside run");

  property p_reset_width;
    @(posedge clk) disable iff (rst)
    $fell(active_low_reset_pin_n) |-> (!active_low_reset_pin_n && !txenable) [*4] ##1 active_low_reset_pin_n;
  endproperty
  a_reset_width: assert property (p_reset_width)
    else $error("reset pulse width wrong");

  property p_alarm_drops_tx;
    @(posedge clk) disable iff (rst)
    (state_reg == S_RUN && alarm_q) |=> !txenable && state_reg == S_FMT;
  endproperty
  a_alarm_drops_tx: assert property (p_alarm_drops_tx)
    else $error("alarm in run did not drop the gate");

  property p_check_blocks;
    @(posedge clk) disable iff (rst)
    (state_reg == S_CHECK && alarm_bad) |=> state_reg != S_CLKOFF;
  endproperty
  a_check_blocks: assert property (p_check_blocks)
    else $error("alarm ignored at check");

  property p_bypass_skips_pll;
    @(posedge clk) disable iff (rst)
    (state_reg == S_MAIN && sif_done && !pll_mode_reg)
      |=> state_reg == S_SYNC;
  endproperty
  a_bypass_skips_pll: assert property (p_bypass_skips_pll)
    else $error("bypass mode touched the pll step");

  property p_sync_in_pulse;
    @(posedge clk) disable iff (rst)
    sync_out |-> pulse_state && lvds_en;
  endproperty
  a_sync_in_pulse: assert property (p_sync_in_pulse)
    else $error("sync pulse outside its step");

  property p_run_after_clkoff;
    @(posedge clk) disable iff (rst)
    $rose(state_reg == S_RUN) |-> $past(state_reg) == S_CLKOFF;
  endproperty
  a_run_after_clkoff: assert property (p_run_after_clkoff)
    else $error("run entered without disabling divider alignment");

  property p_pll_order;
    @(posedge clk) disable iff (rst)
    ($rose(state_reg == S_SYNC) && pll_mode_reg)
      |-> $past(state_reg) == S_PLLOFF;
  endproperty
  a_pll_order: assert property (p_pll_order)
    else $error("pll divider reset not disabled before alignment");

  property p_single_edge;
    @(posedge clk) disable iff (rst)
    $rose(sync_out) |-> sync_out [*8];
  endproperty
  a_single_edge: assert property (p_single_edge)
    else $error("sync pulse too short");

endmodule

/* sim/mcs_dev_model.sv */
// Behavioural converter model: serial registers, sync counters, alarm pin.
`timescale 1ns/1ns
`include "mcs_map.svh"

module mcs_dev_model (
  // Converter control pins
  input wire logic active_low_reset_pin_n,
  input wire logic txenable,
  input wire logic sync_out,
  input wire logic lvds_en,
  output logic alarm_in,
  // Serial pins
  input wire logic sclk,
  input wire logic sdenb_n,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  output logic sdio_in,
  // Bench controls
  input wire logic alarm_pin,
  input wire logic [15:0] alarm_word
);
  // Mode fields are only held; no datapath follows these words.
  logic [15:0] regs [0:127];
  logic [23:0] sh = 24'h000000;
  logic [15:0] w = 16'h0000;
  logic [6:0] ad = 7'h00;
  logic rd_m = 1'b0;
  logic oe = 1'b0;
  logic dout = 1'b0;
  int cnt = 0;
  int ndiv = 0;
  int div = 0;
  int syncs = 0;
  int rst_ns = 0;
  int order_err = 0;
  int alm_rd = 0;
  int lvds_late = 0;
  time t0 = 0;

  assign alarm_in = alarm_pin;
  // The data line has a pull-down, so a released line reads low.
  assign sdio_in = !sdio_oe_n ? sdio_out : (oe ? dout : 1'b0);

  always @(negedge active_low_reset_pin_n)
  begin
    t0 = $time;
    foreach (regs[i]) regs[i] = 16'h0000;
    {ndiv, div, syncs, order_err, alm_rd, lvds_late} = '0;
  end

  always @(posedge active_low_reset_pin_n) rst_ns = $time - t0;

  always @(negedge sdenb_n)
  begin
    cnt = 0;
    rd_m = 1'b0;
  end

  always @(posedge sclk)
  begin
    if (!sdenb_n)
    begin
      sh = {sh[22:0], sdio_out};
      cnt++;
      if (cnt == 8)
      begin
        rd_m = sh[7];
        ad = sh[6:0];
        w = (ad == `MCS_DEV_ALARM) ? alarm_word : regs[ad];
        if (rd_m && ad == `MCS_DEV_ALARM) alm_rd++;
      end
    end
  end

  always @(negedge sclk)
  begin
    if (!sdenb_n && rd_m && cnt >= 8 && cnt < 24)
    begin
      oe = 1'b1;
      dout = w[23-cnt];
    end
  end

  // The gate must stay low while any frame is still being sent.
  always @(posedge sdenb_n)
  begin
    oe = 1'b0;
    if (txenable) order_err++;
    if (cnt == 24 && !rd_m)
    begin
      regs[ad] = sh[15:0];
      if (ad == `MCS_DEV_MAIN && !sh[2] && alm_rd == 0) order_err++;
    end
  end

  // Sync edges align whatever is enabled at that moment.
  always @(posedge sync_out)
  begin
    syncs++;
    if (!lvds_en) lvds_late++;
    if (regs[`MCS_DEV_PLL][11]) ndiv++;
    if (regs[`MCS_DEV_MAIN][2]) div++;
  end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the sync controller against the converter model.
`timescale 1ns/1ns
`include "mcs_map.svh"

module tb_top;
  import mcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic alarm_pin = 1'b0;
  mcs_addr_t reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic [31:0] st;
  logic [15:0] alarm_word = 16'h0000;
  logic active_low_reset_pin_n, txenable, sync_out, lvds_en, alarm_in;
  logic sclk, sdenb_n, sdio_out, sdio_oe_n, sdio_in;
  int mismatches = 0;
  int compares = 0;

  always #4 clk = ~clk;

  mcs_sync_ctrl #(.SETTLE_CYC(4), .SIF_HALF(6)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .active_low_reset_pin_n(active_low_reset_pin_n), .txenable(txenable), .sync_out(sync_out),
    .lvds_en(lvds_en), .alarm_in(alarm_in), .sclk(sclk),
    .sdenb_n(sdenb_n), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .sdio_in(sdio_in)
  );

  mcs_dev_model dev (
    .active_low_reset_pin_n(active_low_reset_pin_n), .txenable(txenable), .sync_out(sync_out),
    .lvds_en(lvds_en), .alarm_in(alarm_in), .sclk(sclk),
    .sdenb_n(sdenb_n), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .sdio_in(sdio_in), .alarm_pin(alarm_pin), .alarm_word(alarm_word)
  );

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input mcs_addr_t a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input mcs_addr_t a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Taken at the edge that closes the cycle in which the data stand.
    @(posedge clk);
    d = reg_rdata;
  endtask

  // Polls status until a bit reaches a value; a hang ends the run.
  task automatic wait_st(input int b, input logic v);
    int n;
    for (n = 0; n < 5000; n++)
    begin
      rd(`MCS_OFS_STATUS, st);
      if (st[b] === v) break;
    end
    if (n == 5000)
    begin
      chk("status wait", 32'(v), 32'(st[b]));
      complete_run();
    end
  endtask

  task automatic t_regs();
    rd(`MCS_OFS_STATUS, st);
    chk("idle status", 32'h00000000, st);
    chk("gate at reset", 32'h0, 32'(txenable));
    rd(8'h40, st);
    chk("unmapped", 32'h00000000, st);
    wr(`MCS_OFS_FMT, 32'h00000008);
    rd(`MCS_OFS_FMT, st);
    chk("fmt image", 32'h00000008, st);
    wr(`MCS_OFS_ALIGN, 32'h00001100);
    $display("test regs done");
  endtask

  // Bypass start with an alarm word present must stop short of the gate.
  task automatic t_fail();
    alarm_word <= 16'h0004;
    wr(`MCS_OFS_CTRL, 32'h00000001);
    wait_st(`MCS_STAT_FAIL, 1'b1);
    chk("gate on fail", 32'h0, 32'(txenable));
    chk("reset width", 32'h1, 32'(dev.rst_ns >= 25));
    chk("fuse sleep", 32'h1, 32'(dev.regs[`MCS_DEV_FUSE][11]));
    chk("align word", 32'h1101, 32'(dev.regs[`MCS_DEV_ALIGN]));
    chk("fmt word", 32'h0008, 32'(dev.regs[`MCS_DEV_FMT]));
    chk("sync edges", 32'h1, 32'(dev.syncs));
    chk("ndiv resets", 32'h0, 32'(dev.ndiv));
    chk("div kept on", 32'h1, 32'(dev.regs[`MCS_DEV_MAIN][2]));
    rd(`MCS_OFS_ALARM, st);
    chk("alarm image", 32'h00000004, st);
    $display("test fail done");
  endtask

  task automatic t_pll();
    alarm_word <= 16'h0000;
    wr(`MCS_OFS_CTRL, 32'h00000003);
    wait_st(`MCS_STAT_RUN, 1'b1);
    chk("gate on", 32'h1, 32'(txenable));
    chk("ndiv resets", 32'h1, 32'(dev.ndiv));
    chk("sync edges", 32'h2, 32'(dev.syncs));
    chk("ndiv off", 32'h0, 32'(dev.regs[`MCS_DEV_PLL][11]));
    chk("div off", 32'h0, 32'(dev.regs[`MCS_DEV_MAIN][2]));
    chk("order", 32'h0, 32'(dev.order_err));
    chk("lvds first", 32'h0, 32'(dev.lvds_late));
    chk("div pulses", 32'h2, 32'(dev.div));
    chk("run status", 32'h00000308, st);
    $display("test pll done");
  endtask

  // An alarm while running drops the gate and redoes the alignment.
  task automatic t_retry();
    alarm_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("gate drop", 32'h0, 32'(txenable));
    alarm_pin <= 1'b0;
    wait_st(`MCS_STAT_RUN, 1'b1);
    chk("gate again", 32'h1, 32'(txenable));
    chk("resync edges", 32'h4, 32'(dev.syncs));
    chk("div off", 32'h0, 32'(dev.regs[`MCS_DEV_MAIN][2]));
    chk("order", 32'h0, 32'(dev.order_err));
    $display("test retry done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fail();
    t_pll();
    t_retry();
    complete_run();
  end
endmodule
